/* hw/asac_cfg.svh */
// timing constants for the async sram host controller
// assumes a 100 MHz core clock; times in ns, counts derived by rounding
`ifndef ASAC_CFG_SVH
`define ASAC_CFG_SVH
`define ASAC_CLK_PERIOD_NS    10
`define ASAC_TRC_NS           10
`define ASAC_TWP_NS           7
`define ASAC_TWP_DRIVE_NS     10
`define ASAC_TDW_NS           5
`define ASAC_WRITE_RELEASE_DELAY_NS          5
`define ASAC_TOW_NS           3
`define ASAC_TOHZ_NS          5
`define ASAC_CEIL(t)          (((t) + `ASAC_CLK_PERIOD_NS - 1) / `ASAC_CLK_PERIOD_NS)
`define ASAC_RD_CYC           (`ASAC_CEIL(`ASAC_TRC_NS) + 1)
`define ASAC_WP_CYC           (`ASAC_CEIL(`ASAC_TWP_NS))
`define ASAC_WP_DRIVE_CYC     (`ASAC_CEIL(`ASAC_TWP_DRIVE_NS))
`define ASAC_TURN_CYC         (`ASAC_CEIL(`ASAC_TOHZ_NS))
`define ASAC_ADDR16_W         16
`define ASAC_ADDR8_W          17
`endif

/* hw/asac_pkg.sv */
// types shared by the async sram host controller files
// assumes asac_cfg.svh for numeric constants
package asac_pkg;
    typedef enum logic [4:0] {
        ASAC_IDLE  = 5'h01,
        ASAC_RD    = 5'h02,
        ASAC_WR    = 5'h04,
        ASAC_WEND  = 5'h08,
        ASAC_TURN  = 5'h10
    } asac_state_t;
endpackage

/* hw/asac_tmr_if.sv */
// timer load/expire carrier between controller and cycle timer
// assumes a single core clock domain
`timescale 1ns/100ps
interface asac_tmr_if;
    logic       load;
    logic [3:0] count;
    logic       done;
    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface

/* hw/asac_timer.sv */
// cycle down-counter: load a count, done stays high while the count sits at zero
// assumes loads come from logic on core_clk
`timescale 1ns/100ps
module asac_timer (
    input  wire logic core_clk,
    input  wire logic rst_b,
    asac_tmr_if.tmr   tmr
);
    logic [3:0] cnt_r;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 4'h0;
        end else if (tmr.load) begin
            cnt_r <= tmr.count;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end

    // done must not depend on load: the controller builds load from done
    assign tmr.done = (cnt_r == 4'h0);
endmodule

/* hw/asac_host.sv */
// host controller for a 64Kx16 / 128Kx8 asynchronous static memory
// assumes requests from core_clk logic; memory pins are asynchronous
// Behaviour
// [RL1] chip select high: memory tri-states and ignores other controls
// [RL2] select low, strobe and output enable high: no transfer
// [RL3] byte mode read: select low, strobe high, output enable low
// [RL4] byte mode write: select low, strobe low, output enable ignored
// [RL5] word mode read drives only lanes whose lane control is low
// [RL6] word mode write stores only lanes whose lane control is low
// [RL7] write happens only while select, strobe and lane control all low
// [RL8] write starts at the later of select or strobe falling
// [RL9] write ends at first of select or strobe rising; data captured there
// [RL10] select falling with or after strobe keeps memory outputs released
// [RL11] output enable low at write start: memory releases bus shortly after
// [RL12] write end under read conditions: memory redrives new address data
// [RL13] output enable high during strobe allows short pulse, else full cycle
// [RL14] address valid by write start and held until write end
// [RL15] address changes only after write end
// [RL16] host never drives data bus while memory may drive it
// [RL17] read address valid no later than select falling
// [RL18] lane controls exist only in word organisation
// [RL19] word organisation uses 16-bit word address
// [RL20] byte organisation uses 17-bit byte address
// [RL21] word mode with both lane controls high: nothing stored or driven
// [RL22] memory retains data; read returns last written value
`timescale 1ns/100ps
`include "asac_cfg.svh"
module asac_host
    import asac_pkg::*;
#(
    parameter bit WORD_MODE = 1'b1,
    parameter int DW        = WORD_MODE ? 16 : 8,
    parameter int AW        = WORD_MODE ? `ASAC_ADDR16_W : `ASAC_ADDR8_W,
    parameter int BW        = WORD_MODE ? 2 : 1
) (
    input  wire logic          core_clk,
    input  wire logic          rst_b,
    input  wire logic          req_valid,
    output logic               req_ready,
    input  wire logic          req_write,
    input  wire logic [AW-1:0] req_addr,
    input  wire logic [DW-1:0] req_wdata,
    input  wire logic [BW-1:0] req_lane_n,
    input  wire logic          req_oe_low,
    output logic               rsp_valid,
    output logic [DW-1:0]      rsp_rdata,
    output logic [AW-1:0]      mem_addr,
    output logic               mem_cs_n,
    output logic               mem_we_n,
    output logic               mem_oe_n,
    output logic [BW-1:0]      mem_lane_n,
    input  wire logic [DW-1:0] mem_dq_i,
    output logic [DW-1:0]      mem_dq_o,
    output logic               mem_dq_oe
);
    asac_state_t     state_r, state_nxt;
    logic [AW-1:0]   addr_r;
    logic [DW-1:0]   wdata_r;
    logic [DW-1:0]   dq_s1_r, dq_s2_r;
    logic [BW-1:0]   lane_r;
    logic            cs_n_r, we_n_r, oe_n_r, dq_oe_r, oe_low_r;
    logic            rsp_valid_r;
    logic [DW-1:0]   rdata_r;
    asac_tmr_if      tif();

    asac_timer u_timer (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .tmr      (tif)
    );

    wire accept    = req_valid && (state_r == ASAC_IDLE);
    wire tmr_done  = tif.done;
    // lane mask: byte mode has a single always-enabled lane  see [RL18]
    wire [BW-1:0] lane_sel = WORD_MODE ? req_lane_n : {BW{1'b0}};
    // strobe count becomes ASAC_WP_DRIVE_CYC when output enable stays low; at 100 MHz both counts are 1  see [RL13]
    wire [3:0] wp_cnt = req_oe_low ? 4'(`ASAC_WP_DRIVE_CYC) : 4'(`ASAC_WP_CYC);

    assign req_ready = (state_r == ASAC_IDLE);
    assign tif.load  = accept || (state_r == ASAC_WR && tmr_done)
                     || (state_r == ASAC_RD && tmr_done);
    assign tif.count = accept ? (req_write ? wp_cnt : 4'(`ASAC_RD_CYC))
                     : 4'(`ASAC_TURN_CYC);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ASAC_IDLE: if (req_valid) state_nxt = req_write ? ASAC_WR : ASAC_RD;
            ASAC_RD:   if (tmr_done) state_nxt = ASAC_TURN;
            ASAC_WR:   if (tmr_done) state_nxt = ASAC_WEND;
            ASAC_WEND: state_nxt = ASAC_TURN;
            ASAC_TURN: if (tmr_done) state_nxt = ASAC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) state_r <= ASAC_IDLE;
        else        state_r <= state_nxt;
    end

    // address, lanes and data held for the whole access  see [RL14] [RL15] [RL17]
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_r   <= '0;
            wdata_r  <= '0;
            lane_r   <= '1;
            oe_low_r <= 1'b0;
        end else if (accept) begin
            addr_r   <= req_addr;
            wdata_r  <= req_wdata;
            lane_r   <= lane_sel;
            oe_low_r <= req_oe_low && req_write;
        end
    end

    // write: select and strobe fall together, so memory never drives  see [RL8] [RL10]
    // strobe rises first and ends the write  see [RL9] [RL7]
    wire cs_n_nxt  = !(state_nxt == ASAC_RD || state_nxt == ASAC_WR
                     || state_nxt == ASAC_WEND);
    wire we_n_nxt  = !(state_nxt == ASAC_WR);
    wire oe_n_nxt  = !(state_nxt == ASAC_RD || (state_nxt == ASAC_WR
                     && (accept ? req_oe_low : oe_low_r)));
    // host drives data during the strobe and one cycle after it, in ASAC_WEND  see [RL16] [RL11]
    wire dq_oe_nxt = (state_nxt == ASAC_WR) || (state_nxt == ASAC_WEND);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_n_r  <= 1'b1;
            we_n_r  <= 1'b1;
            oe_n_r  <= 1'b1;
            dq_oe_r <= 1'b0;
        end else begin
            cs_n_r  <= cs_n_nxt;  // see [RL1] [RL2]
            we_n_r  <= we_n_nxt;  // see [RL4]
            oe_n_r  <= oe_n_nxt;  // see [RL3]
            dq_oe_r <= dq_oe_nxt;
        end
    end

    // pins of the memory are asynchronous: two stages before use
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dq_s1_r <= '0;
            dq_s2_r <= '0;
        end else begin
            dq_s1_r <= mem_dq_i;
            dq_s2_r <= dq_s1_r;
        end
    end

    // sample read data at end of read; unselected lanes read zero  see [RL5] [RL21] [RL22]
    wire [DW-1:0] lane_mask;
    genvar g;
    generate
        for (g = 0; g < BW; g++) begin : g_lane
            assign lane_mask[g*8 +: 8] = {8{!lane_r[g]}};
        end
    endgenerate
    wire rd_done = (state_r == ASAC_RD) && tmr_done;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_valid_r <= 1'b0;
            rdata_r     <= '0;
        end else begin
            rsp_valid_r <= rd_done;
            if (rd_done) rdata_r <= dq_s2_r & lane_mask;
        end
    end

    assign rsp_valid  = rsp_valid_r;
    assign rsp_rdata  = rdata_r;
    assign mem_addr   = addr_r;           // see [RL19] [RL20]
    assign mem_cs_n   = cs_n_r;
    assign mem_we_n   = we_n_r;
    assign mem_oe_n   = oe_n_r;
    assign mem_lane_n = lane_r;           // see [RL6]
    assign mem_dq_o   = wdata_r;
    assign mem_dq_oe  = dq_oe_r;

    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    wr_cs_we_a:  assert property (!mem_we_n |-> !mem_cs_n)  // see [RL7]
        else $error("strobe low without select");
    wr_no_oe_a:  assert property ($fell(mem_we_n) |-> $fell(mem_cs_n))  // see [RL10]
        else $error("select fell before strobe");
    wr_end_a:    assert property ($rose(mem_we_n) |-> !mem_cs_n)  // see [RL9]
        else $error("select rose no later than strobe");
    addr_hold_a: assert property (!mem_cs_n && !$fell(mem_cs_n)  // see [RL14]
                                  |-> $stable(mem_addr))
        else $error("address moved inside access");
    no_fight_a:  assert property (mem_dq_oe  // see [RL16]
                                  |-> mem_we_n == 1'b0 || $past(!mem_we_n))
        else $error("host drives bus outside write");
    rd_oe_a:     assert property (!mem_oe_n && mem_we_n |-> !mem_dq_oe)  // see [RL16]
        else $error("host drives during read");
    wp_oe_a:     assert property (!mem_we_n && !$fell(mem_we_n)  // see [RL13]
                                  |-> $stable(mem_oe_n))
        else $error("output enable moved inside strobe");
    rd_rsp_a:    assert property ($fell(mem_oe_n) && mem_we_n |-> ##[1:6] rsp_valid)  // see [RL3]
        else $error("read answer missing");
    idle_cs_a:   assert property (state_r == ASAC_IDLE |-> mem_cs_n && mem_we_n)  // see [RL1]
        else $error("select active while idle");

    rd_c:  cover property (rsp_valid);
    wr_c:  cover property ($rose(mem_we_n));
    wroe_c: cover property (!mem_we_n && !mem_oe_n);
endmodule

/* verif/asac_sram_model.sv */
// behavioural static memory standing on the controller's memory pins
// assumes host drive and its enable are fed in; resolved bus goes back out
`timescale 1ns/100ps
module asac_sram_model #(
    parameter bit WORD_MODE = 1'b1,
    parameter int DW        = 16,
    parameter int AW        = 16,
    parameter int BW        = 2
) (
    input  wire logic [AW-1:0] addr,
    input  wire logic          cs_n,
    input  wire logic          we_n,
    input  wire logic          oe_n,
    input  wire logic [BW-1:0] lane_n,
    input  wire logic [DW-1:0] host_dq,
    input  wire logic          host_oe,
    output logic [DW-1:0]      bus,
    output logic               clash
);
    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] lane_en;
    logic [DW-1:0] drv_en;
    logic [DW-1:0] rd;
    always_comb begin
        for (int i = 0; i < DW; i++) begin
            lane_en[i] = WORD_MODE ? !lane_n[i/8] : 1'b1;
        end
    end
    assign drv_en = (!cs_n && we_n && !oe_n) ? lane_en : '0;
    assign rd     = mem[addr];
    // released lanes show the inverse, never a stale match
    assign bus    = host_oe ? host_dq : ((rd & drv_en) | (~rd & ~drv_en));
    assign clash  = host_oe && (|drv_en);
    // write lands where strobe or select rises first, with the data seen there
    always @(posedge we_n or posedge cs_n) begin
        if (!cs_n || !we_n) begin
            for (int i = 0; i < DW; i++) begin
                if (lane_en[i]) mem[addr][i] = host_oe ? host_dq[i] : 1'bx;
            end
        end
    end
endmodule

/* verif/async_sram_access_port_tb.sv */
// bench for the async sram host controller in word organisation
// assumes asac_sram_model on the memory pins
`timescale 1ns/100ps
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin miscompares++; \
    $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module async_sram_access_port_tb;
    typedef struct packed {
        logic        wr;
        logic [15:0] a;
        logic [15:0] d;
        logic [1:0]  ln;
        logic        ol;
    } asac_row_t;
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic        req_oe_low = 1'b0;
    logic [15:0] req_addr = 16'h0000;
    logic [15:0] req_wdata = 16'h0000;
    logic [1:0]  req_lane_n = 2'h0;
    logic        req_ready, rsp_valid, mem_cs_n, mem_we_n, mem_oe_n, mem_dq_oe, clash;
    logic [15:0] rsp_rdata, mem_addr, mem_dq_i, mem_dq_o;
    logic [1:0]  mem_lane_n;
    int          miscompares = 0;
    int          compares = 0;
    asac_row_t   rows [12] = '{
        {1'h1, 16'h0010, 16'hA5C3, 2'h0, 1'h0}, {1'h0, 16'h0010, 16'hA5C3, 2'h0, 1'h0},
        {1'h1, 16'h0010, 16'h1177, 2'h2, 1'h1}, {1'h0, 16'h0010, 16'hA577, 2'h0, 1'h0},
        {1'h1, 16'h0010, 16'h2288, 2'h1, 1'h0}, {1'h0, 16'h0010, 16'h0077, 2'h2, 1'h0},
        {1'h0, 16'h0010, 16'h2200, 2'h1, 1'h0}, {1'h1, 16'h0010, 16'hFFFF, 2'h3, 1'h1},
        {1'h0, 16'h0010, 16'h2277, 2'h0, 1'h0}, {1'h1, 16'hFFFF, 16'h0F0F, 2'h0, 1'h1},
        {1'h0, 16'hFFFF, 16'h0F0F, 2'h0, 1'h0}, {1'h0, 16'hFFFF, 16'h0000, 2'h3, 1'h0}};
    asac_host #(.WORD_MODE(1'b1)) dut_u (
        .core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_lane_n(req_lane_n), .req_oe_low(req_oe_low), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .mem_cs_n(mem_cs_n),
        .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .mem_lane_n(mem_lane_n),
        .mem_dq_i(mem_dq_i), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe));
    asac_sram_model #(.WORD_MODE(1'b1), .DW(16), .AW(16), .BW(2)) mem_u (
        .addr(mem_addr), .cs_n(mem_cs_n), .we_n(mem_we_n), .oe_n(mem_oe_n),
        .lane_n(mem_lane_n), .host_dq(mem_dq_o), .host_oe(mem_dq_oe),
        .bus(mem_dq_i), .clash(clash));
    always #5 core_clk = ~core_clk;
    task automatic summarize();
        if (miscompares == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // one request, driven at falling edges; reads are checked on arrival
    task automatic op(input asac_row_t r);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        {req_write, req_addr, req_wdata, req_lane_n, req_oe_low} = r;
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        `CHK("acc_cs", 1'b0, mem_cs_n)
        `CHK("acc_addr", r.a, mem_addr)
        `CHK("acc_lane", r.ln, mem_lane_n)
        `CHK("acc_oe", (r.wr && !r.ol), mem_oe_n)
        if (!r.wr) begin
            n = 1;
            while (rsp_valid !== 1'b1 && n < 20) begin
                @(negedge core_clk);
                n++;
            end
            `CHK("rd_lat", 4, n)
            `CHK("rdata", r.d, rsp_rdata)
        end
    endtask
    // pin watch on every cycle out of reset
    always @(negedge core_clk) begin
        if (rst_b) begin
            `CHK("clash", 1'b0, clash)
            if (mem_we_n === 1'b0) begin
                `CHK("wr_cs", 1'b0, mem_cs_n)
                `CHK("wr_dq", 1'b1, mem_dq_oe)
            end
        end
    end
    initial begin
        repeat (4) @(negedge core_clk);
        `CHK("rst_cs", 1'b1, mem_cs_n)
        `CHK("rst_dq", 1'b0, mem_dq_oe)
        `CHK("rst_ln", 2'h3, mem_lane_n)
        rst_b = 1'b1;
        foreach (rows[i]) begin
            op(rows[i]);
        end
        // reset lands mid-strobe; earlier data must survive
        op({1'h1, 16'h0020, 16'hBEEF, 2'h0, 1'h0});
        @(negedge core_clk);
        rst_b = 1'b0;
        @(negedge core_clk);
        `CHK("mid_rst_we", 1'b1, mem_we_n)
        rst_b = 1'b1;
        op({1'h0, 16'h0010, 16'h2277, 2'h0, 1'h0});
        summarize();
    end
    initial begin
        #100000;
        miscompares++;
        summarize();
    end
endmodule
